// [rtl/uep_ctrl.v]
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uep_regs.vh"
// Contract
// - sixteen endpoint registers, upper byte zero
// - ep0 bit7 enables direct low-speed link
// - ep0 bit6 disables automatic nak retry
// - bits 7,6 only ep0 in host mode
// - bit4 forbids setup when tx and rx
// - bit3 enables endpoint reception
// - bit2 enables endpoint transmission
// - bit1 reports endpoint stall status
// - bit0 enables handshake packets
// - pwm bit15 enables generator, else output held at bit9 level
// - pwm bit9 selects output polarity
// - pwm bit8 enables counter; others zero
module uep_ctrl (
    input  wire        mclk,
    input  wire        reset,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        tok_valid,
    input  wire [1:0]  tok_pid,
    input  wire [3:0]  tok_ep,
    input  wire        stall_event,
    input  wire [3:0]  stall_ep,
    output reg         tok_accept,
    output reg         tok_handshake,
    output reg         low_speed_direct_enable,
    output reg         nak_retry_enable,
    output wire        vbus_pwm_out,
    output wire        irq
);
    reg  [15:0] ep_r [0:15];
    reg  [15:0] vbus_pwm_control_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_en_r;
    reg         host_mode_r;
    reg         ack_r;
    wire        req;
    wire        wr;
    wire        is_ep;
    wire [3:0]  ep_idx;
    wire [15:0] tok_reg;
    wire [2:0]  ev;
    reg  [31:0] rd_nxt;
    reg         acc_nxt;
    reg         setup_rej;
    integer     i;

    // mask of writable endpoint bits for a given index
    function [15:0] ep_mask;
        input [3:0] idx;
        input       host;
        begin
            ep_mask = 16'h001f;
            if (idx == 4'h0 && host) begin
                ep_mask = 16'h00df;
            end
        end
    endfunction

    // one cycle of wait, then the answer
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr              = avs_write & ~ack_r;
    assign is_ep           = (avs_address[7:6] == 2'b00);
    assign ep_idx          = avs_address[5:2];
    assign tok_reg         = ep_r[tok_ep];

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < 16; i = i + 1) begin
                ep_r[i] <= `UEP_EP_RESET;
            end
            vbus_pwm_control_r <= `UEP_PWM_RESET;
            irq_en_r           <= 3'h0;
            host_mode_r        <= 1'b0;
        end else begin
            if (wr && avs_byteenable[0] && is_ep) begin
                // stall bit stays hardware owned; write keeps it
                ep_r[ep_idx] <= (avs_writedata[15:0] & ep_mask(ep_idx, host_mode_r)
                                & ~(16'h0001 << `UEP_EP_STALL))
                                | (ep_r[ep_idx] & (16'h0001 << `UEP_EP_STALL));
            end
            if (wr && avs_address == `UEP_PWM_CON && avs_byteenable[1]) begin
                vbus_pwm_control_r <= avs_writedata[15:0] & 16'h8300;
            end
            if (wr && avs_address == `UEP_IRQ_EN && avs_byteenable[0]) begin
                irq_en_r <= avs_writedata[2:0];
            end
            if (wr && avs_address == `UEP_MODE && avs_byteenable[0]) begin
                host_mode_r <= avs_writedata[0];
                if (!avs_writedata[0]) begin
                    ep_r[0][7:6] <= 2'b00;
                end
            end
            if (stall_event) begin
                ep_r[stall_ep][`UEP_EP_STALL] <= 1'b1;
            end
            if (wr && avs_byteenable[0] && is_ep && stall_event && stall_ep == ep_idx) begin
                ep_r[ep_idx][`UEP_EP_STALL] <= 1'b1;
            end
        end
    end

    // token admission decisions
    always @* begin
        acc_nxt   = 1'b0;
        setup_rej = 1'b0;
        case (tok_pid)
            `UEP_TOK_OUT: acc_nxt = tok_reg[`UEP_EP_RXEN];
            `UEP_TOK_IN:  acc_nxt = tok_reg[`UEP_EP_TXEN];
            `UEP_TOK_SETUP: begin
                acc_nxt = tok_reg[`UEP_EP_RXEN] & tok_reg[`UEP_EP_TXEN]
                          & ~tok_reg[`UEP_EP_CONDIS];
                setup_rej = ~acc_nxt;
            end
            default: acc_nxt = 1'b0;
        endcase
    end

    assign ev = {setup_rej & tok_valid, ~acc_nxt & tok_valid, stall_event};

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            tok_accept              <= 1'b0;
            tok_handshake           <= 1'b0;
            low_speed_direct_enable <= 1'b0;
            nak_retry_enable        <= 1'b0;
            irq_stat_r              <= 3'h0;
        end else begin
            tok_accept    <= tok_valid & acc_nxt;
            tok_handshake <= tok_valid & acc_nxt & tok_reg[`UEP_EP_HSHK];
            low_speed_direct_enable <= host_mode_r & ep_r[0][`UEP_EP_LSDIR];
            nak_retry_enable        <= host_mode_r & ~ep_r[0][`UEP_EP_RETRYD];
            if (wr && avs_address == `UEP_IRQ_CLR && avs_byteenable[0]) begin
                irq_stat_r <= (irq_stat_r & ~avs_writedata[2:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    always @* begin
        rd_nxt = 32'h00000000;
        if (is_ep) begin
            rd_nxt = {16'h0000, ep_r[ep_idx]};
        end else begin
            case (avs_address)
                `UEP_PWM_CON:  rd_nxt = {16'h0000, vbus_pwm_control_r};
                `UEP_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
                `UEP_IRQ_EN:   rd_nxt = {29'h0, irq_en_r};
                `UEP_MODE:     rd_nxt = {31'h0, host_mode_r};
                default:       rd_nxt = 32'h00000000;
            endcase
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rd_nxt;
        end
    end

    uep_pwm u_pwm (
        .mclk    (mclk),
        .reset   (reset),
        .gen_en  (vbus_pwm_control_r[`UEP_PWM_EN]),
        .cnt_en  (vbus_pwm_control_r[`UEP_PWM_VBUS_COUNTER_ENABLE]),
        .pol     (vbus_pwm_control_r[`UEP_PWM_POL]),
        .duty    (8'h80),
        .pwm_out (vbus_pwm_out)
    );
endmodule
`default_nettype wire

// [rtl/uep_pwm.v]
`timescale 1ns/1ps
`default_nettype none
`include "uep_regs.vh"
// vbus pwm output stage: counter and compare gated by control bits
module uep_pwm (
    input  wire        mclk,
    input  wire        reset,
    input  wire        gen_en,
    input  wire        cnt_en,
    input  wire        pol,
    input  wire [7:0]  duty,
    output reg         pwm_out
);
    reg  [7:0] cnt_r;
    wire       act;

    assign act = (cnt_r < duty);

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r   <= 8'h00;
            pwm_out <= 1'b0;
        end else begin
            if (gen_en && cnt_en) begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (gen_en) begin
                pwm_out <= act ^ pol;
            end else begin
                pwm_out <= pol;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/uep_regs.vh]
`ifndef UEP_REGS_VH
`define UEP_REGS_VH
// register byte addresses (word aligned)
`define UEP_EP_BASE        8'h00
`define UEP_PWM_CON        8'h40
`define UEP_IRQ_STAT       8'h44
`define UEP_IRQ_CLR        8'h48
`define UEP_IRQ_EN         8'h4c
`define UEP_MODE           8'h50
// endpoint control fields
`define UEP_EP_HSHK        0
`define UEP_EP_STALL       1
`define UEP_EP_TXEN        2
`define UEP_EP_RXEN        3
`define UEP_EP_CONDIS      4
`define UEP_EP_RETRYD      6
`define UEP_EP_LSDIR       7
`define UEP_EP_RESET       16'h0000
// pwm control fields
`define UEP_PWM_VBUS_COUNTER_ENABLE      8
`define UEP_PWM_POL        9
`define UEP_PWM_EN         15
`define UEP_PWM_RESET      16'h0000
// interrupt status bits
`define UEP_IRQ_STALL      0
`define UEP_IRQ_REFUSE     1
`define UEP_IRQ_SETUPREJ   2
// token pids
`define UEP_TOK_OUT        2'h0
`define UEP_TOK_IN         2'h1
`define UEP_TOK_SETUP      2'h2
`endif

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uep_regs.vh"
module tb_top;
    logic        mclk = 0, reset = 1, avs_read = 0, avs_write = 0, stall_event = 0, host = 0;
    logic [7:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, q;
    logic [3:0]  stall_ep = 0, be = 4'hf;
    wire  [31:0] avs_readdata;
    wire  [1:0]  tok_pid;
    wire  [3:0]  tok_ep;
    wire         avs_waitrequest, tok_valid, tok_accept, tok_handshake, lsd, nre, pwm, irq;
    integer      error_cnt = 0, checks = 0, ep_m[16], i, p, e;
    always #20 mclk = ~mclk;
    uep_ctrl DUT (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid),
        .tok_pid(tok_pid), .tok_ep(tok_ep), .stall_event(stall_event), .stall_ep(stall_ep),
        .tok_accept(tok_accept), .tok_handshake(tok_handshake), .low_speed_direct_enable(lsd),
        .nak_retry_enable(nre), .vbus_pwm_out(pwm), .irq(irq));
    uep_tok_src u_src (.mclk(mclk), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep));
    task end_sim;
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        integer n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        if (n >= 20) begin error_cnt++; end_sim; end
    endtask
    task wep(input integer n, input [31:0] d);
        bus(1, 8'(4 * n), d);
        ep_m[n] = (d & 'h1d) | (ep_m[n] & 2) | ((n == 0 && host) ? d & 'hc0 : 0);
    endtask
    task lsr(input [1:0] x);
        repeat (3) @(posedge mclk);
        chk({lsd, nre}, x);
    endtask
    initial begin
        void'($urandom(87228));
        for (i = 0; i < 16; i++) ep_m[i] = 0;
        repeat (6) @(posedge mclk);
        reset <= 0;
        for (i = 0; i < 16; i++) begin bus(0, 8'(4 * i), 0); chk(q, 0); end
        bus(0, `UEP_PWM_CON, 0); chk(q, 0);
        bus(0, 8'h80, 0); chk(q, 0);
        bus(1, `UEP_MODE, 1); host = 1;
        for (i = 0; i < 16; i++) begin
            wep(i, $urandom);
            bus(0, 8'(4 * i), 0);
            chk(q, ep_m[i]);
        end
        // a write without the low byte lane must leave the endpoint untouched
        be <= 4'h2; bus(1, 8'h04, 'h1f); be <= 4'hf;
        bus(0, 8'h04, 0); chk(q, ep_m[1]);
        wep(0, 'hc0); lsr(2'b10);
        wep(0, 'h40); lsr(2'b00);
        wep(0, 'h00); lsr(2'b01);
        bus(1, `UEP_MODE, 0); host = 0; lsr(2'b00);
        for (i = 0; i < 16; i++) begin
            wep(i, (i == 14) ? 'h0d : (i == 15) ? 'h1c : $urandom);
            for (p = 0; p < 3; p++) begin
                u_src.send(p, i);
                @(negedge mclk);
                e = (p == 0) ? ep_m[i][3] : (p == 1) ? ep_m[i][2] :
                    ep_m[i][3] & ep_m[i][2] & !ep_m[i][4];
                chk(tok_accept, e);
                chk(tok_handshake, e & ep_m[i][0]);
            end
        end
        bus(1, `UEP_IRQ_CLR, 7); bus(1, `UEP_IRQ_EN, 1); chk(irq, 0);
        @(posedge mclk); stall_event <= 1; stall_ep <= 5;
        @(posedge mclk); stall_event <= 0; stall_ep <= 4'ha;
        repeat (2) @(posedge mclk); chk(irq, 1);
        ep_m[5] |= 2; bus(0, 8'h14, 0); chk(q, ep_m[5]);
        bus(1, `UEP_IRQ_EN, 0); @(posedge mclk); chk(irq, 0);
        bus(1, `UEP_IRQ_CLR, 1); bus(1, `UEP_IRQ_EN, 1); @(posedge mclk); chk(irq, 0);
        bus(1, `UEP_PWM_CON, 'hffff); bus(0, `UEP_PWM_CON, 0); chk(q, 'h8300);
        bus(1, `UEP_PWM_CON, 'h0200); repeat (3) @(posedge mclk); chk(pwm, 1);
        bus(1, `UEP_PWM_CON, 'h0000); repeat (3) @(posedge mclk); chk(pwm, 0);
        // running counter: half of every 256-cycle period is active
        bus(1, `UEP_PWM_CON, 'h8100); repeat (4) @(posedge mclk);
        e = 0; repeat (256) begin @(posedge mclk); e += pwm; end
        chk(e, 128);
        // frozen counter: output must not move
        bus(1, `UEP_PWM_CON, 'h8000); repeat (4) @(posedge mclk);
        e = 0; repeat (16) begin @(posedge mclk); e += pwm; end
        chk(e % 16, 0);
        end_sim;
    end
    initial begin #2000000; error_cnt++; end_sim; end
endmodule
`default_nettype wire

// [sim/uep_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module uep_monitor (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tok_valid,
    input wire logic        stall_event,
    input wire logic        tok_accept,
    input wire logic        tok_handshake,
    input wire logic        low_speed_direct_enable,
    input wire logic        vbus_pwm_out,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_wait_one: assert property ($rose(avs_read | avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait length");
    chk_idle_ready: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("idle wait");
    chk_rdata_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
        else $error("readdata moved");
    chk_acc_cause: assert property (tok_accept |-> $past(tok_valid))
        else $error("accept without token");
    chk_hshk_acc: assert property (tok_handshake |-> tok_accept)
        else $error("handshake without accept");
    chk_reset_zero: assert property ($fell(reset) |-> !(tok_accept | irq | vbus_pwm_out))
        else $error("output after reset");
    chk_lsd_write: assert property (!$past(avs_write) && !$past(avs_write, 2)
        |-> $stable(low_speed_direct_enable)) else $error("low speed moved");
    chk_irq_cause: assert property ($rose(irq) |-> $past(stall_event | tok_valid | avs_write)
        || $past(stall_event | tok_valid | avs_write, 2)) else $error("irq cause");
    cover property (tok_handshake);
    cover property (irq);
    cover property (low_speed_direct_enable);
endmodule
bind uep_ctrl uep_monitor u_mon (.mclk(mclk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tok_valid(tok_valid), .stall_event(stall_event), .tok_accept(tok_accept),
    .tok_handshake(tok_handshake), .low_speed_direct_enable(low_speed_direct_enable),
    .vbus_pwm_out(vbus_pwm_out), .irq(irq));
`default_nettype wire

// [sim/uep_tok_src.sv]
`timescale 1ns/1ps
`default_nettype none
// bus partner issuing one token per call; idle lines show the inverse value
module uep_tok_src (
    input wire logic   mclk,
    output logic       tok_valid = 0,
    output logic [1:0] tok_pid = 0,
    output logic [3:0] tok_ep = 0
);
    task send(input [1:0] p, input [3:0] e);
        begin
            @(posedge mclk);
            tok_valid <= 1;
            tok_pid <= p;
            tok_ep <= e;
            @(posedge mclk);
            tok_valid <= 0;
            tok_pid <= ~p;
            tok_ep <= ~e;
        end
    endtask
endmodule
`default_nettype wire
